// >>> rtl/alarm_pkg.sv
// Package for the process alarm evaluator: type codes, widths, timing.
// Assumes signed process data in display units, one 40 MHz clock.
package alarm_pkg;
  localparam int NUM_ALARMS = 3;
  localparam int VAL_W = 16;
  localparam int TYPE_W = 5;
  localparam int DELAY_W = 10;
  localparam int CLK_HZ = 40000000;
  localparam int SEC_NS = 1000000000;
  localparam int CLK_NS = 25;
  localparam int TICK_CYCLES = SEC_NS / CLK_NS;
  localparam logic [DELAY_W-1:0] DELAY_MAX_S = 10'h3e7;
  localparam logic [TYPE_W-1:0] T_OFF = 5'h00;
  localparam logic [TYPE_W-1:0] T_BAND_OUT = 5'h01;
  localparam logic [TYPE_W-1:0] T_DEV_HI = 5'h02;
  localparam logic [TYPE_W-1:0] T_DEV_LO = 5'h03;
  localparam logic [TYPE_W-1:0] T_BAND_IN = 5'h04;
  localparam logic [TYPE_W-1:0] T_BAND_OUT_SB = 5'h05;
  localparam logic [TYPE_W-1:0] T_DEV_HI_SB = 5'h06;
  localparam logic [TYPE_W-1:0] T_DEV_LO_SB = 5'h07;
  localparam logic [TYPE_W-1:0] T_ABS_HI = 5'h08;
  localparam logic [TYPE_W-1:0] T_ABS_LO = 5'h09;
  localparam logic [TYPE_W-1:0] T_ABS_HI_SB = 5'h0a;
  localparam logic [TYPE_W-1:0] T_ABS_LO_SB = 5'h0b;
  localparam logic [TYPE_W-1:0] T_LOOP_BREAK = 5'h0c;
  localparam logic [TYPE_W-1:0] T_RATE = 5'h0d;
  localparam logic [TYPE_W-1:0] T_TGT_HI = 5'h0e;
  localparam logic [TYPE_W-1:0] T_TGT_LO = 5'h0f;
  localparam logic [TYPE_W-1:0] T_MV_HI = 5'h10;
  localparam logic [TYPE_W-1:0] T_MV_LO = 5'h11;
  localparam logic [TYPE_W-1:0] T_MAX = 5'h11;
  localparam logic [TYPE_W-1:0] TYPE_RESET = T_DEV_HI;
endpackage : alarm_pkg

// >>> rtl/alarm_delay.sv
// ON/OFF delay filter for one alarm channel.
// Assumes a one-cycle seconds tick from the same clock.
`timescale 1ns/1ps
module alarm_delay (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_cond,
  input wire logic [alarm_pkg::DELAY_W-1:0] i_on_delay,
  input wire logic [alarm_pkg::DELAY_W-1:0] i_off_delay,
  output logic o_out
);
  import alarm_pkg::*;

  typedef struct packed {
    logic out;
    logic [DELAY_W-1:0] secs;
  } dly_state_t;

  dly_state_t s_q;
  dly_state_t s_d;

  // Count whole seconds while input disagrees with output; any return restarts
  always_comb begin
    logic [DELAY_W-1:0] lim;
    lim = s_q.out ? i_off_delay : i_on_delay;
    s_d = s_q;
    if (i_cond == s_q.out) begin
      s_d.secs = '0;
    end else if (lim == '0 || (i_tick && s_q.secs + 10'h001 >= lim)) begin
      s_d.out = i_cond;
      s_d.secs = '0;
    end else if (i_tick && s_q.secs != DELAY_MAX_S) begin
      s_d.secs = s_q.secs + 10'h001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_out = s_q.out;
endmodule : alarm_delay

// >>> rtl/process_alarm_evaluator.sv
// Process alarm evaluator: per-channel alarm type, compare, standby, delays.
// Assumes process data arrives synchronous to i_clk; config from a CPU port.
//
// Overview of operation
// - Each channel keeps its own alarm type code.
// - Reset sets every channel's type to 2, deviation upper limit.
// - Each channel's result drives its own auxiliary output.
// - Separate ON and OFF delays, 0 to 999 whole seconds.
// - With heater detection fitted, channel one defaults to heater alarm duty.
// - Code 1: active outside target minus low to target plus high.
// - Code 4: active inside that deviation band.
// - Code 2: active when process exceeds target by alarm value or more.
// - Code 3: active when process is below target by alarm value or more.
// - Codes 5, 6, 7 are 1, 2, 3 with standby sequence.
// - Code 8: active when process value is above alarm value.
// - Code 9: active when process value is below alarm value.
// - Codes 10, 11 are 8, 9 with standby sequence.
// - Code 12, loop break, accepted only on channel one.
// - Code 14: active when target value is above alarm value.
// - Code 15: active when target value is below alarm value.
// - Code 16: active when output level is above alarm value.
// - Code 17: active when output level is below alarm value.
// - Codes 1, 4, 5 hold separate upper and lower deviations.
// - Code 5 stays off while the two hysteresis regions overlap.
// - Heat/cool: upper level alarm uses heating, lower uses cooling.
`timescale 1ns/1ps
module process_alarm_evaluator (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_heater_detect_fitted,
  input wire logic i_cfg_we,
  input wire logic [1:0] i_cfg_chan,
  input wire logic [alarm_pkg::TYPE_W-1:0] i_cfg_type,
  input wire logic signed [alarm_pkg::VAL_W-1:0] i_cfg_value,
  input wire logic signed [alarm_pkg::VAL_W-1:0] i_cfg_dev_hi,
  input wire logic signed [alarm_pkg::VAL_W-1:0] i_cfg_dev_lo,
  input wire logic [alarm_pkg::DELAY_W-1:0] i_cfg_on_delay,
  input wire logic [alarm_pkg::DELAY_W-1:0] i_cfg_off_delay,
  input wire logic signed [alarm_pkg::VAL_W-1:0] i_hysteresis,
  input wire logic i_assign_alarm1,
  input wire logic signed [alarm_pkg::VAL_W-1:0] i_process_value,
  input wire logic signed [alarm_pkg::VAL_W-1:0] i_target_value,
  input wire logic signed [alarm_pkg::VAL_W-1:0] i_manipulated_output_level,
  input wire logic signed [alarm_pkg::VAL_W-1:0] i_cooling_output_level,
  input wire logic i_heat_cool_mode,
  input wire logic i_loop_break_alarm,
  input wire logic i_rate_alarm,
  input wire logic i_heater_fault_alarm,
  input wire logic i_standby_release,
  output logic o_cfg_reject,
  output logic o_alarm1_heater_duty,
  output logic [alarm_pkg::NUM_ALARMS-1:0] o_aux_out
);
  import alarm_pkg::*;

  typedef struct packed {
    logic [NUM_ALARMS-1:0][TYPE_W-1:0] atype;
    logic [NUM_ALARMS-1:0][VAL_W-1:0] value;
    logic [NUM_ALARMS-1:0][VAL_W-1:0] dev_hi;
    logic [NUM_ALARMS-1:0][VAL_W-1:0] dev_lo;
    logic [NUM_ALARMS-1:0][DELAY_W-1:0] on_dly;
    logic [NUM_ALARMS-1:0][DELAY_W-1:0] off_dly;
    logic [NUM_ALARMS-1:0] standby;
    logic [NUM_ALARMS-1:0] aux;
    logic heater_duty;
    logic strap_taken;
    logic reject;
    logic tick;
    logic [31:0] tick_cnt;
  } eval_state_t;

  eval_state_t s_q;
  eval_state_t s_d;
  logic [NUM_ALARMS-1:0] raw;
  logic [NUM_ALARMS-1:0] delayed;

  // Widened signed compare avoids overflow on target plus deviation
  function automatic logic signed [VAL_W:0] wide(input logic [VAL_W-1:0] v);
    wide = {v[VAL_W-1], v};
  endfunction : wide

  // Standby-sequence types hold off until process first sits in the safe zone
  function automatic logic is_standby(input logic [TYPE_W-1:0] t);
    is_standby = (t == T_BAND_OUT_SB) || (t == T_DEV_HI_SB) || (t == T_DEV_LO_SB) ||
                 (t == T_ABS_HI_SB) || (t == T_ABS_LO_SB);
  endfunction : is_standby

  // Raw condition of each channel, before standby and delays
  always_comb begin
    logic signed [VAL_W:0] pv;
    logic signed [VAL_W:0] sp;
    logic signed [VAL_W:0] mv;
    logic signed [VAL_W:0] cv;
    logic signed [VAL_W:0] x;
    logic signed [VAL_W:0] hi;
    logic signed [VAL_W:0] lo;
    logic signed [VAL_W:0] hy;
    // Loop temporaries start from a known value on every pass
    x = '0;
    hi = '0;
    lo = '0;
    pv = wide(i_process_value);
    sp = wide(i_target_value);
    mv = wide(i_manipulated_output_level);
    cv = wide(i_cooling_output_level);
    hy = wide(i_hysteresis);
    for (int i = 0; i < NUM_ALARMS; i++) begin
      x = wide(s_q.value[i]);
      hi = sp + wide(s_q.dev_hi[i]);
      lo = sp - wide(s_q.dev_lo[i]);
      case (s_q.atype[i])
        T_OFF: raw[i] = 1'b0;
        T_BAND_OUT: raw[i] = (pv > hi) || (pv < lo);
        T_BAND_OUT_SB: raw[i] = ((pv > hi) || (pv < lo)) && (hi - hy > lo + hy);
        T_BAND_IN: raw[i] = (pv >= lo) && (pv <= hi);
        T_DEV_HI, T_DEV_HI_SB: raw[i] = (pv - sp) >= x;
        T_DEV_LO, T_DEV_LO_SB: raw[i] = (sp - pv) >= x;
        T_ABS_HI, T_ABS_HI_SB: raw[i] = pv > x;
        T_ABS_LO, T_ABS_LO_SB: raw[i] = pv < x;
        T_LOOP_BREAK: raw[i] = i_loop_break_alarm;
        T_RATE: raw[i] = i_rate_alarm;
        T_TGT_HI: raw[i] = sp > x;
        T_TGT_LO: raw[i] = sp < x;
        T_MV_HI: raw[i] = mv > x;
        T_MV_LO: raw[i] = (i_heat_cool_mode ? cv : mv) < x;
        default: raw[i] = 1'b0;
      endcase
    end
  end

  // Configuration, standby latch, seconds tick and output register
  always_comb begin
    s_d = s_q;
    s_d.reject = 1'b0;
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 32'h1;
    end
    // Strap sampled once after reset release, never under reset
    if (!s_q.strap_taken) begin
      s_d.strap_taken = 1'b1;
      s_d.heater_duty = i_heater_detect_fitted;
    end else if (i_assign_alarm1) begin
      s_d.heater_duty = 1'b0;
    end
    if (i_cfg_we) begin
      if (i_cfg_chan >= 2'(NUM_ALARMS) || i_cfg_type > T_MAX ||
          (i_cfg_type == T_LOOP_BREAK && i_cfg_chan != 2'h0)) begin
        s_d.reject = 1'b1;
      end else begin
        s_d.atype[i_cfg_chan] = i_cfg_type;
        s_d.value[i_cfg_chan] = i_cfg_value;
        s_d.dev_hi[i_cfg_chan] = i_cfg_dev_hi;
        s_d.dev_lo[i_cfg_chan] = i_cfg_dev_lo;
        s_d.on_dly[i_cfg_chan] = (i_cfg_on_delay > DELAY_MAX_S) ? DELAY_MAX_S : i_cfg_on_delay;
        s_d.off_dly[i_cfg_chan] = (i_cfg_off_delay > DELAY_MAX_S) ? DELAY_MAX_S : i_cfg_off_delay;
        s_d.standby[i_cfg_chan] = is_standby(i_cfg_type);
      end
    end
    // Standby clears once the condition is seen absent; new type re-arms it
    for (int i = 0; i < NUM_ALARMS; i++) begin
      if (s_q.standby[i] && (!raw[i] || i_standby_release)) begin
        if (!(i_cfg_we && i_cfg_chan == 2'(i))) begin
          s_d.standby[i] = 1'b0;
        end
      end
      s_d.aux[i] = delayed[i] && !s_q.standby[i];
    end
    if (s_q.heater_duty) begin
      s_d.aux[0] = i_heater_fault_alarm;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
      for (int i = 0; i < NUM_ALARMS; i++) begin
        s_q.atype[i] <= TYPE_RESET;
        s_q.standby[i] <= 1'b0;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // One delay filter per channel, fed the standby-gated condition
  for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_dly
    alarm_delay u_dly (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_tick(s_q.tick),
      .i_cond(raw[g] && !s_q.standby[g]),
      .i_on_delay(s_q.on_dly[g]),
      .i_off_delay(s_q.off_dly[g]),
      .o_out(delayed[g])
    );
  end

  assign o_cfg_reject = s_q.reject;
  assign o_alarm1_heater_duty = s_q.heater_duty;
  assign o_aux_out = s_q.aux;
endmodule : process_alarm_evaluator

// >>> tb/alarm_props.sv
// Checker for the process alarm evaluator, watching its ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module alarm_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_heater_detect_fitted,
  input wire logic i_cfg_we,
  input wire logic [1:0] i_cfg_chan,
  input wire logic [alarm_pkg::TYPE_W-1:0] i_cfg_type,
  input wire logic i_assign_alarm1,
  input wire logic i_heater_fault_alarm,
  input wire logic o_cfg_reject,
  input wire logic o_alarm1_heater_duty,
  input wire logic [alarm_pkg::NUM_ALARMS-1:0] o_aux_out
);
  import alarm_pkg::*;
  logic good_wr;
  logic off2_d;
  logic off2_q;
  // Accepted write: legal channel, known type, loop break only on channel 0
  assign good_wr = i_cfg_we && i_cfg_chan < 2'h3 && i_cfg_type <= T_MAX &&
                   !(i_cfg_type == T_LOOP_BREAK && i_cfg_chan != 2'h0);
  // Remembers that channel 2 was switched off
  always_comb begin
    off2_d = off2_q;
    if (good_wr && i_cfg_chan == 2'h2) begin
      off2_d = (i_cfg_type == T_OFF);
    end
  end
  always_ff @(posedge i_clk) begin
    off2_q <= i_rst ? 1'b0 : off2_d;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  bad_type_a: assert property (i_cfg_we && i_cfg_type > T_MAX |=> o_cfg_reject) else $error("type not refused");
  bad_chan_a: assert property (i_cfg_we && i_cfg_chan == 2'h3 |=> o_cfg_reject) else $error("chan not refused");
  loop_break_only_a: assert property (i_cfg_we && i_cfg_type == T_LOOP_BREAK && i_cfg_chan != 2'h0
    |=> o_cfg_reject) else $error("loop break taken off channel 0");
  good_write_a: assert property (good_wr |=> !o_cfg_reject) else $error("legal write refused");
  reset_clear_a: assert property (disable iff (1'b0) i_rst |=> o_aux_out == 3'h0 && !o_alarm1_heater_duty
    && !o_cfg_reject) else $error("outputs not cleared by reset");
  duty_take_a: assert property ($fell(i_rst) && !i_assign_alarm1
    |=> o_alarm1_heater_duty == $past(i_heater_detect_fitted)) else $error("heater duty not taken");
  duty_clear_a: assert property (i_assign_alarm1 |=> !o_alarm1_heater_duty) else $error("duty kept");
  duty_fault_a: assert property ((o_alarm1_heater_duty && i_heater_fault_alarm) [*3] |-> o_aux_out[0])
    else $error("heater fault not on output 0");
  off_chan_a: assert property (off2_q && $past(off2_q, 3) |-> !o_aux_out[2]) else $error("off channel on");
endmodule : alarm_props
bind process_alarm_evaluator alarm_props u_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_heater_detect_fitted(i_heater_detect_fitted), .i_cfg_we(i_cfg_we), .i_cfg_chan(i_cfg_chan),
  .i_cfg_type(i_cfg_type), .i_assign_alarm1(i_assign_alarm1), .i_heater_fault_alarm(i_heater_fault_alarm),
  .o_cfg_reject(o_cfg_reject), .o_alarm1_heater_duty(o_alarm1_heater_duty), .o_aux_out(o_aux_out));

// >>> tb/process_source.sv
// Partner model: the controller's process data feeding the evaluator.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/1ps
module process_source (
  input wire logic i_clk,
  output logic signed [alarm_pkg::VAL_W-1:0] o_pv,
  output logic signed [alarm_pkg::VAL_W-1:0] o_sp,
  output logic signed [alarm_pkg::VAL_W-1:0] o_mv,
  output logic signed [alarm_pkg::VAL_W-1:0] o_cool,
  output logic signed [alarm_pkg::VAL_W-1:0] o_hyst,
  output logic o_heat_cool
);
  import alarm_pkg::*;
  // Standard control, all levels zero until told otherwise
  initial {o_pv, o_sp, o_mv, o_cool, o_hyst, o_heat_cool} = '0;
  // Process, target and output level move together
  task automatic levels(input int pv, input int sp, input int mv);
    @(negedge i_clk);
    o_pv = VAL_W'(pv);
    o_sp = VAL_W'(sp);
    o_mv = VAL_W'(mv);
  endtask : levels
  // Cooling level only counts in heat/cool mode
  task automatic mode(input int cool, input int hyst, input logic hc);
    @(negedge i_clk);
    o_cool = VAL_W'(cool);
    o_hyst = VAL_W'(hyst);
    o_heat_cool = hc;
  endtask : mode
endmodule : process_source

// >>> tb/testbench.sv
// Self-checking bench for the process alarm evaluator.
// Assumes the partner supplies process data; config is driven from here.
`timescale 1ns/1ps
module testbench;
  import alarm_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic fit = 1'b0, we = 1'b0, asg = 1'b0, lb = 1'b0, rate = 1'b0, hf = 1'b0, rel = 1'b0;
  logic [1:0] ch = 2'h0;
  logic [TYPE_W-1:0] ty = T_OFF;
  logic signed [VAL_W-1:0] x = '0, dh = '0, dl = '0, pv, sp, mv, cool, hy;
  logic hc, rej, duty;
  logic [NUM_ALARMS-1:0] aux;
  int failures = 0, total_checks = 0;
  always #12.5 i_clk = ~i_clk;
  process_source u_src (.i_clk(i_clk), .o_pv(pv), .o_sp(sp), .o_mv(mv), .o_cool(cool), .o_hyst(hy), .o_heat_cool(hc));
  // Delays stay zero: a one-second tick is far beyond a short run
  process_alarm_evaluator u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_heater_detect_fitted(fit), .i_cfg_we(we),
    .i_cfg_chan(ch), .i_cfg_type(ty), .i_cfg_value(x), .i_cfg_dev_hi(dh), .i_cfg_dev_lo(dl),
    .i_cfg_on_delay(10'h000), .i_cfg_off_delay(10'h000), .i_hysteresis(hy), .i_assign_alarm1(asg),
    .i_process_value(pv), .i_target_value(sp), .i_manipulated_output_level(mv), .i_cooling_output_level(cool),
    .i_heat_cool_mode(hc), .i_loop_break_alarm(lb), .i_rate_alarm(rate), .i_heater_fault_alarm(hf),
    .i_standby_release(rel), .o_cfg_reject(rej), .o_alarm1_heater_duty(duty), .o_aux_out(aux));
  task automatic conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [2:0] e, input logic [2:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One-cycle write pulse; returns where a reject pulse is visible
  task automatic wr(input logic [1:0] c, input logic [4:0] t, input int v, input int h, input int l);
    @(negedge i_clk);
    we = 1'b1;
    ch = c;
    ty = t;
    x = VAL_W'(v);
    dh = VAL_W'(h);
    dl = VAL_W'(l);
    @(negedge i_clk);
    we = 1'b0;
  endtask : wr
  task automatic rst_run(input logic f);
    @(negedge i_clk);
    i_rst = 1'b1;
    fit = f;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask : rst_run
  // Channel 2 evaluation; levels go first so a standby write sees them
  task automatic row(input logic w, input logic [4:0] t, input int v, input int h, input int l,
                     input int p, input int s, input int m, input logic e);
    u_src.levels(p, s, m);
    if (w) wr(2'h2, t, v, h, l);
    repeat (4) @(negedge i_clk);
    chk("aux2", {2'b0, e}, {2'b0, aux[2]});
  endtask : row
  task automatic t_default;
    u_src.levels(10, 0, 0);
    repeat (4) @(negedge i_clk);
    chk("aux", 3'h7, aux);
    u_src.levels(-10, 0, 0);
    repeat (4) @(negedge i_clk);
    chk("aux", 3'h0, aux);
  endtask : t_default
  task automatic t_types;
    row(1, T_BAND_OUT, 0, 10, 5, 111, 100, 0, 1'b1);
    row(0, T_BAND_OUT, 0, 10, 5, 100, 100, 0, 1'b0);
    row(1, T_BAND_IN, 0, 10, 5, 100, 100, 0, 1'b1);
    row(0, T_BAND_IN, 0, 10, 5, 94, 100, 0, 1'b0);
    row(1, T_DEV_HI, 10, 0, 0, 110, 100, 0, 1'b1);
    row(0, T_DEV_HI, 10, 0, 0, 109, 100, 0, 1'b0);
    row(1, T_DEV_LO, 10, 0, 0, 90, 100, 0, 1'b1);
    row(0, T_DEV_LO, 10, 0, 0, 91, 100, 0, 1'b0);
    row(1, T_ABS_HI, 100, 0, 0, 101, 0, 0, 1'b1);
    row(1, T_ABS_LO, 100, 0, 0, 99, 0, 0, 1'b1);
    row(1, T_TGT_HI, 100, 0, 0, 0, 101, 0, 1'b1);
    row(1, T_TGT_LO, 100, 0, 0, 0, 99, 0, 1'b1);
    row(1, T_MV_HI, 50, 0, 0, 0, 0, 60, 1'b1);
    row(1, T_MV_LO, 50, 0, 0, 0, 0, 40, 1'b1);
    row(1, T_OFF, 0, 0, 0, 500, 0, 0, 1'b0);
  endtask : t_types
  task automatic t_standby;
    row(1, T_DEV_HI_SB, 10, 0, 0, 120, 100, 0, 1'b0);
    row(0, T_DEV_HI_SB, 10, 0, 0, 100, 100, 0, 1'b0);
    row(0, T_DEV_HI_SB, 10, 0, 0, 120, 100, 0, 1'b1);
    row(1, T_ABS_HI_SB, 100, 0, 0, 150, 0, 0, 1'b0);
    rel = 1'b1;
    row(0, T_ABS_HI_SB, 100, 0, 0, 150, 0, 0, 1'b1);
    rel = 1'b0;
    u_src.mode(0, 5, 1'b0);
    row(1, T_BAND_OUT_SB, 0, 1, 1, 100, 100, 0, 1'b0);
    row(0, T_BAND_OUT_SB, 0, 1, 1, 200, 100, 0, 1'b0);
    u_src.mode(60, 0, 1'b1);
    row(1, T_MV_LO, 50, 0, 0, 0, 0, 40, 1'b0);
    u_src.mode(0, 0, 1'b0);
  endtask : t_standby
  task automatic t_reject;
    wr(2'h1, T_LOOP_BREAK, 0, 0, 0);
    chk("rej", 3'h1, {2'b0, rej});
    wr(2'h3, T_DEV_HI, 0, 0, 0);
    chk("rej", 3'h1, {2'b0, rej});
    wr(2'h1, 5'h12, 0, 0, 0);
    chk("rej", 3'h1, {2'b0, rej});
    wr(2'h0, T_LOOP_BREAK, 0, 0, 0);
    chk("rej", 3'h0, {2'b0, rej});
    lb = 1'b1;
    rate = 1'b1;
    row(1, T_RATE, 0, 0, 0, 0, 0, 0, 1'b1);
    chk("aux0", 3'h1, {2'b0, aux[0]});
    lb = 1'b0;
    rate = 1'b0;
  endtask : t_reject
  // Second reset mid-run with heater detection fitted
  task automatic t_heater;
    hf = 1'b1;
    rst_run(1'b1);
    chk("duty", 3'h1, {2'b0, duty});
    chk("aux0", 3'h1, {2'b0, aux[0]});
    @(negedge i_clk);
    asg = 1'b1;
    @(negedge i_clk);
    asg = 1'b0;
    chk("duty", 3'h0, {2'b0, duty});
    hf = 1'b0;
  endtask : t_heater
  initial begin
    rst_run(1'b0);
    t_default;
    t_types;
    t_standby;
    t_reject;
    t_heater;
    conclude;
  end
  // Watchdog well past the roughly 190 cycles the scenarios need
  initial begin
    repeat (4000) @(posedge i_clk);
    failures++;
    conclude;
  end
endmodule : testbench
